// ==== inc/pgp_pkg.sv ====
// Package with register map, reset values and mode codes for the port 2/3 block
package pgp_pkg;
	localparam int          ADDR_W        = 16;
	localparam int          DATA_W        = 8;
	localparam logic [15:0] ADDR_P2_DIR   = 16'hFFC1;
	localparam logic [15:0] ADDR_P3_DIR   = 16'hFFC4;
	localparam logic [15:0] ADDR_P2_LATCH = 16'hFFC3;
	localparam logic [15:0] ADDR_P3_LATCH = 16'hFFC6;
	localparam logic [15:0] ADDR_P2_PULL  = 16'hFFD8;
	localparam logic [7:0]  RST_ZERO      = 8'h00;
	localparam logic [7:0]  ALL_ONES      = 8'hFF;
	localparam logic [7:0]  UNMAPPED_READ = 8'h00;
	localparam logic [2:0]  MODE_EXP_LAST = 3'h4;
	localparam logic [2:0]  MODE_ROM_LAST = 3'h6;
	localparam logic [2:0]  MODE_SINGLE   = 3'h7;
	localparam logic [2:0]  MODE_FIRST    = 3'h1;
endpackage

// ==== hdl/pgp_port23.sv ====
// Port 2 and port 3 general-purpose I/O with register port
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
module pgp_port23 #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              nrst,
	// Mode and standby
	input  wire logic [2:0]        op_mode,
	input  wire logic              hw_standby,
	input  wire logic              sw_standby,
	// Register port
	input  wire logic [31:0]       reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_write,
	input  wire logic              reg_read,
	output logic      [7:0]        reg_rdata,
	// Bus side of the pins in expanded modes
	input  wire logic [WIDTH-1:0]  addr_hi,
	input  wire logic [WIDTH-1:0]  data_hi_out,
	input  wire logic              data_hi_drive,
	output logic      [WIDTH-1:0]  data_hi_in,
	// Port 2 pads
	input  wire logic [WIDTH-1:0]  p2_pad_in,
	output logic      [WIDTH-1:0]  p2_pad_out,
	output logic      [WIDTH-1:0]  p2_pad_oe_n,
	output logic      [WIDTH-1:0]  p2_pullup_on,
	// Port 3 pads
	input  wire logic [WIDTH-1:0]  p3_pad_in,
	output logic      [WIDTH-1:0]  p3_pad_out,
	output logic      [WIDTH-1:0]  p3_pad_oe_n
);
	logic [WIDTH-1:0] port2_output_latch;
	logic [WIDTH-1:0] port2_direction;
	logic [WIDTH-1:0] port2_pullup_enable;
	logic [WIDTH-1:0] port3_direction;
	logic [WIDTH-1:0] port3_output_latch;
	logic [WIDTH-1:0] p2_sync1;
	logic [WIDTH-1:0] p2_pin;
	logic [WIDTH-1:0] p3_sync1;
	logic [WIDTH-1:0] p3_pin;
	logic [WIDTH-1:0] p3_out_hold;
	logic [WIDTH-1:0] p3_oe_hold;

	wire logic [15:0]      low_addr;
	wire logic             mode_exp;
	wire logic             mode_rom;
	wire logic             mode_single;
	wire logic             wr_p2_dir;
	wire logic             wr_p2_latch;
	wire logic             wr_p2_pull;
	wire logic             wr_p3_dir;
	wire logic             wr_p3_latch;
	wire logic [WIDTH-1:0] p2_dir_eff;
	wire logic [WIDTH-1:0] p2_read_val;
	wire logic [WIDTH-1:0] p3_read_val;
	wire logic [WIDTH-1:0] next_p2_out;
	wire logic [WIDTH-1:0] next_p2_oe;
	wire logic [WIDTH-1:0] next_p2_pull;
	wire logic [WIDTH-1:0] next_p3_out;
	wire logic [WIDTH-1:0] next_p3_oe;
	logic      [7:0]       next_rdata;

	// Latch where driven, pin elsewhere
	function automatic logic [WIDTH-1:0] mix_read(
		input logic [WIDTH-1:0] dir,
		input logic [WIDTH-1:0] latch,
		input logic [WIDTH-1:0] pin
	);
		mix_read = (dir & latch) | (~dir & pin);
	endfunction

	assign low_addr    = reg_addr[15:0];
	assign mode_exp    = (op_mode >= pgp_pkg::MODE_FIRST) && (op_mode <= pgp_pkg::MODE_EXP_LAST);
	assign mode_rom    = (op_mode > pgp_pkg::MODE_EXP_LAST) && (op_mode <= pgp_pkg::MODE_ROM_LAST);
	assign mode_single = (op_mode == pgp_pkg::MODE_SINGLE);
	assign wr_p2_dir   = reg_write && (low_addr == pgp_pkg::ADDR_P2_DIR);
	assign wr_p2_latch = reg_write && (low_addr == pgp_pkg::ADDR_P2_LATCH);
	assign wr_p2_pull  = reg_write && (low_addr == pgp_pkg::ADDR_P2_PULL);
	assign wr_p3_dir   = reg_write && (low_addr == pgp_pkg::ADDR_P3_DIR);
	assign wr_p3_latch = reg_write && (low_addr == pgp_pkg::ADDR_P3_LATCH);

	// Direction forced to ones in ROM-less expanded modes
	assign p2_dir_eff  = mode_exp ? pgp_pkg::ALL_ONES : port2_direction;
	assign p2_read_val = mix_read(p2_dir_eff, port2_output_latch, p2_pin);
	assign p3_read_val = mix_read(port3_direction, port3_output_latch, p3_pin);

	// Address bits in expanded modes, latch in single-chip mode
	assign next_p2_out = mode_single ? port2_output_latch : addr_hi;
	assign next_p2_oe  = p2_dir_eff;
	assign next_p2_pull = (mode_rom || mode_single) && !hw_standby
		? (port2_pullup_enable & ~port2_direction) : pgp_pkg::RST_ZERO;

	// Software standby freezes what port 3 outputs show
	assign next_p3_out = sw_standby ? p3_out_hold
		: (mode_single ? port3_output_latch : data_hi_out);
	assign next_p3_oe  = sw_standby ? p3_oe_hold
		: (mode_single ? port3_direction : {WIDTH{data_hi_drive}});

	always_comb begin
		next_rdata = pgp_pkg::UNMAPPED_READ;
		if (low_addr == pgp_pkg::ADDR_P2_DIR)
			next_rdata = pgp_pkg::ALL_ONES;
		else if (low_addr == pgp_pkg::ADDR_P2_LATCH)
			next_rdata = p2_read_val;
		else if (low_addr == pgp_pkg::ADDR_P2_PULL)
			next_rdata = port2_pullup_enable;
		else if (low_addr == pgp_pkg::ADDR_P3_DIR)
			next_rdata = pgp_pkg::ALL_ONES;
		else if (low_addr == pgp_pkg::ADDR_P3_LATCH)
			next_rdata = p3_read_val;
	end

	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			p2_sync1 <= pgp_pkg::RST_ZERO;
			p2_pin   <= pgp_pkg::RST_ZERO;
			p3_sync1 <= pgp_pkg::RST_ZERO;
			p3_pin   <= pgp_pkg::RST_ZERO;
		end else begin
			p2_sync1 <= p2_pad_in;
			p2_pin   <= p2_sync1;
			p3_sync1 <= p3_pad_in;
			p3_pin   <= p3_sync1;
		end
	end

	// Port 2 registers; hardware standby clears like reset
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			port2_output_latch  <= pgp_pkg::RST_ZERO;
			port2_direction     <= pgp_pkg::RST_ZERO;
			port2_pullup_enable <= pgp_pkg::RST_ZERO;
		end else if (hw_standby) begin
			port2_output_latch  <= pgp_pkg::RST_ZERO;
			port2_direction     <= pgp_pkg::RST_ZERO;
			port2_pullup_enable <= pgp_pkg::RST_ZERO;
		end else begin
			if (wr_p2_latch)
				port2_output_latch <= reg_wdata;
			if (wr_p2_dir && !mode_exp)
				port2_direction <= reg_wdata;
			if (wr_p2_pull)
				port2_pullup_enable <= reg_wdata;
		end
	end

	// Port 3 registers
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			port3_direction    <= pgp_pkg::RST_ZERO;
			port3_output_latch <= pgp_pkg::RST_ZERO;
		end else if (hw_standby) begin
			port3_direction    <= pgp_pkg::RST_ZERO;
			port3_output_latch <= pgp_pkg::RST_ZERO;
		end else begin
			if (wr_p3_dir)
				port3_direction <= reg_wdata;
			if (wr_p3_latch)
				port3_output_latch <= reg_wdata;
		end
	end

	// Pad and read outputs, all registered
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			reg_rdata    <= pgp_pkg::RST_ZERO;
			p2_pad_out   <= pgp_pkg::RST_ZERO;
			p2_pad_oe_n  <= pgp_pkg::ALL_ONES;
			p2_pullup_on <= pgp_pkg::RST_ZERO;
			p3_pad_out   <= pgp_pkg::RST_ZERO;
			p3_pad_oe_n  <= pgp_pkg::ALL_ONES;
			p3_out_hold  <= pgp_pkg::RST_ZERO;
			p3_oe_hold   <= pgp_pkg::RST_ZERO;
			data_hi_in   <= pgp_pkg::RST_ZERO;
		end else if (hw_standby) begin
			reg_rdata    <= pgp_pkg::RST_ZERO;
			p2_pad_out   <= pgp_pkg::RST_ZERO;
			p2_pad_oe_n  <= pgp_pkg::ALL_ONES;
			p2_pullup_on <= pgp_pkg::RST_ZERO;
			p3_pad_out   <= pgp_pkg::RST_ZERO;
			p3_pad_oe_n  <= pgp_pkg::ALL_ONES;
			p3_out_hold  <= pgp_pkg::RST_ZERO;
			p3_oe_hold   <= pgp_pkg::RST_ZERO;
			data_hi_in   <= pgp_pkg::RST_ZERO;
		end else begin
			if (reg_read)
				reg_rdata <= next_rdata;
			p2_pad_out   <= next_p2_out;
			p2_pad_oe_n  <= ~next_p2_oe;
			p2_pullup_on <= next_p2_pull;
			p3_pad_out   <= next_p3_out;
			p3_pad_oe_n  <= ~next_p3_oe;
			p3_out_hold  <= next_p3_out;
			p3_oe_hold   <= next_p3_oe;
			data_hi_in   <= p3_pin;
		end
	end
endmodule

// ==== verif/pgp_port23_assertions.sv ====
// Checker of pad and register-port timing for the port 2/3 block
`timescale 1ns/10ps
module pgp_port23_checker #(
	parameter int WIDTH = 8
) (
	// Clock, reset, mode, standby
	input wire logic             clock,
	input wire logic             nrst,
	input wire logic [2:0]       op_mode,
	input wire logic             hw_standby,
	input wire logic             sw_standby,
	// Register port
	input wire logic [31:0]      reg_addr,
	input wire logic             reg_read,
	input wire logic [7:0]       reg_rdata,
	// Bus side and pads
	input wire logic [WIDTH-1:0] addr_hi,
	input wire logic [WIDTH-1:0] data_hi_out,
	input wire logic             data_hi_drive,
	input wire logic [WIDTH-1:0] p2_pad_out,
	input wire logic [WIDTH-1:0] p2_pad_oe_n,
	input wire logic [WIDTH-1:0] p2_pullup_on,
	input wire logic [WIDTH-1:0] p3_pad_out,
	input wire logic [WIDTH-1:0] p3_pad_oe_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// Standby excluded: pads freeze or float there
	wire run      = !hw_standby && !sw_standby;
	wire bus_mode = op_mode >= 3'h1 && op_mode <= 3'h6;
	wire low_mode = op_mode >= 3'h1 && op_mode <= 3'h4;
	sequence s_dir_read;
		reg_read && !hw_standby && reg_addr[15:0] == pgp_pkg::ADDR_P3_DIR;
	endsequence
	a_p3_dir_ones: assert property (s_dir_read |=> reg_rdata == 8'hFF)
		else $error("direction read not all ones");
	a_low_pull_off: assert property (low_mode && $stable(op_mode) |-> p2_pullup_on == 8'h00)
		else $error("pull-up on in low mode");
	a_hw_pull_off: assert property (hw_standby |=> p2_pullup_on == 8'h00)
		else $error("pull-up on in hw standby");
	a_hw_p3_float: assert property ((hw_standby && !sw_standby) [*2] |-> p3_pad_oe_n == 8'hFF)
		else $error("port 3 driven in hw standby");
	a_bus_oe: assert property (bus_mode && run |=> p3_pad_oe_n == {WIDTH{!$past(data_hi_drive)}})
		else $error("port 3 enable not bus drive");
	a_bus_data: assert property (bus_mode && run && data_hi_drive |=> p3_pad_out == $past(data_hi_out))
		else $error("port 3 value not bus data");
	a_p2_addr_out: assert property (low_mode && run |=> !p2_pad_oe_n && p2_pad_out == $past(addr_hi))
		else $error("port 2 not address out");
	a_sw_freeze: assert property (sw_standby && !hw_standby |=> $stable(p3_pad_out) && $stable(p3_pad_oe_n))
		else $error("port 3 moved in sw standby");
endmodule
bind pgp_port23 pgp_port23_checker #(.WIDTH(WIDTH)) u_chk (.*);

// ==== verif/pgp_port23_bench.sv ====
// Self-checking bench for the port 2/3 block
`timescale 1ns/10ps
module pgp_port23_bench;
	logic        clock, nrst, hw_standby, sw_standby, reg_write, reg_read, data_hi_drive;
	logic [2:0]  op_mode;
	logic [31:0] reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, addr_hi, data_hi_out, data_hi_in, p2_pad_in, p2_pad_out;
	logic [7:0]  p2_pad_oe_n, p2_pullup_on, p3_pad_in, p3_pad_out, p3_pad_oe_n;
	int          error_cnt = 0, comparisons = 0, cycles = 0;
	pgp_port23 #(.WIDTH(8)) dut (.*);
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// Whole run needs about 130 cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			error_cnt++;
			end_sim;
		end
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [7:0] e, input string n);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 chk(n, e, reg_rdata);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic stby(input bit hw);
		@(posedge clock);
		if (hw) hw_standby <= 1'b1;
		else sw_standby <= 1'b1;
		wt(3);
		@(posedge clock);
		hw_standby <= 1'b0;
		sw_standby <= 1'b0;
		#1;
	endtask
	task automatic t_p3;
		wr(32'h1234FFC4, 8'hF0);
		wr(32'h0000FFC6, 8'hA5);
		wt(4);
		chk("p3 out", 8'hA0, p3_pad_out & 8'hF0);
		chk("p3 oe_n", 8'h0F, p3_pad_oe_n);
		rd(32'h5678FFC6, 8'hAC, "p3 read");
		rd(32'h0000FFC4, 8'hFF, "p3 dir read");
		@(posedge clock);
		sw_standby <= 1'b1;
		wr(32'h0000FFC6, 8'h5A);
		wt(3);
		chk("p3 out frozen", 8'hA5, p3_pad_out);
		@(posedge clock);
		sw_standby <= 1'b0;
		wt(1);
		chk("p3 oe_n held", 8'h0F, p3_pad_oe_n);
		stby(1'b1);
		rd(32'h0000FFC6, 8'h3C, "p3 pins");
		wr(32'h0000FFC4, 8'hFF);
		rd(32'h0000FFC6, 8'h00, "p3 latch");
	endtask
	task automatic t_p2;
		wr(32'h0000FFC1, 8'h0F);
		wr(32'h0000FFC3, 8'h5A);
		wr(32'h0000FFD8, 8'hFF);
		wt(4);
		chk("p2 pull", 8'hF0, p2_pullup_on);
		chk("p2 oe_n", 8'hF0, p2_pad_oe_n);
		chk("p2 out", 8'h0A, p2_pad_out & 8'h0F);
		rd(32'h0000FFC3, 8'hCA, "p2 read");
		rd(32'h0000FFD8, 8'hFF, "p2 pull read");
		stby(1'b0);
		chk("p2 pull sw", 8'hF0, p2_pullup_on);
		stby(1'b1);
		rd(32'h0000FFD8, 8'h00, "p2 pull clr");
		wr(32'h0000FFC1, 8'hFF);
		rd(32'h0000FFC3, 8'h00, "p2 latch clr");
	endtask
	task automatic t_modes;
		for (int m = 1; m < 7; m++) begin
			@(posedge clock);
			op_mode <= 3'(m);
			wr(32'h0000FFD8, 8'hFF);
			wr(32'h0000FFC1, 8'h00);
			wt(4);
			chk("p3 bus oe", 8'h00, p3_pad_oe_n);
			chk("p3 bus out", 8'h96, p3_pad_out);
			chk("bus in", 8'h3C, data_hi_in);
			chk("p2 pull", m < 5 ? 8'h00 : 8'hFF, p2_pullup_on);
			chk("p2 oe", m < 5 ? 8'h00 : 8'hFF, p2_pad_oe_n);
		end
		rd(32'h0000FF00, 8'h00, "unmapped");
	endtask
	task automatic end_sim;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		{nrst, hw_standby, sw_standby, reg_write, reg_read, reg_addr, reg_wdata} = '0;
		{op_mode, data_hi_drive, data_hi_out, addr_hi} = {3'h7, 1'b1, 8'h96, 8'h3E};
		{p2_pad_in, p3_pad_in} = {8'hC3, 8'h3C};
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		t_p3;
		t_p2;
		t_modes;
		end_sim;
	end
endmodule
